// File: verilog/bmr_pkg.sv
package bmr_pkg;
  // ****************************************
  // Register selection codes on the serial side
  // ****************************************
  localparam logic [1:0] SEL_TEMPERATURE = 2'h0;
  localparam logic [1:0] SEL_VOLTAGE = 2'h1;
  localparam logic [1:0] SEL_CURRENT = 2'h2;
  localparam logic [1:0] SEL_OFFSET = 2'h3;
  // ****************************************
  // Field layouts and reset values
  // ****************************************
  localparam int TEMP_FRAC_ZEROS = 3;
  localparam logic [12:0] TEMP_MAX_CODE = 13'h0FA0;
  localparam logic [12:0] TEMP_MIN_CODE = 13'h1920;
  localparam logic [5:0] VOLT_PAD = 6'h00;
  localparam int OFFSET_SIGN_BITS = 4;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [9:0] CUR_POS_LIMIT = 10'h1FF;
  localparam logic [9:0] CUR_NEG_LIMIT = 10'h200;
  // ****************************************
  // Timing
  // ****************************************
  localparam longint CLK_PERIOD_PS = 40000;
  localparam longint SAMPLE_PERIOD_PS = 64'd27460000000;
  localparam int SAMPLE_CYCLES = int'(SAMPLE_PERIOD_PS / CLK_PERIOD_PS);
  localparam int SAMPLE_CNT_W = 20;
  typedef enum logic [1:0] {
    BMR_CUR_IDLE = 2'b00,
    BMR_CUR_WAIT = 2'b01,
    BMR_CUR_CONV = 2'b10
  } bmr_cur_state_t;
endpackage

// File: verilog/bmr_readout.sv
// What this block does
// - Temperature is a 13-bit two's complement value, 0.03125 C per step.
// - Temperature word has three zero low bits, signed value above, sign on top.
// - Temperature codes span -55 to +125 C: 7D00h and C900h at the ends.
// - One 10-bit voltage conversion runs per convert command taken while idle, never otherwise.
// - Voltage result goes into a two-byte register, 10 mV per step, 10.23 V full.
// - Voltage result is unsigned in the low ten bits, e.g. 5 V reads 01F4h.
// - A configuration bit picks supply or auxiliary input; only one is stored.
// - Current is sampled with no command, once every 27.46 ms.
// - Current sampling happens only while the current converter enable is 1.
// - Current word: bits 0 to 9 value, six sign copies above, 0.2441 mV step.
// - Each finished current sample plus the offset, saturated to the 10-bit signed range, is written to the current result.
// - Offset register is two bytes, always readable, written only while the current converter enable is 0; its four top bits carry the sign.
// - Results reach the host serially as register contents it reads out.
// - Every byte and command on the serial bus moves least significant bit first.
// - Current result holds the last finished sample; a running one never shows.
module bmr_readout #(
  parameter int SAMPLE_PERIOD = bmr_pkg::SAMPLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic current_adc_enable,
  input wire logic cfg_use_aux,
  input wire logic cmd_convert_v,
  input wire logic temp_done,
  input wire logic [12:0] temp_raw,
  input wire logic volt_done,
  input wire logic [9:0] volt_code,
  input wire logic cur_done,
  input wire logic [9:0] cur_raw,
  input wire logic [1:0] reg_sel,
  input wire logic rd_load,
  input wire logic rd_shift,
  input wire logic wr_shift,
  input wire logic wr_bit,
  input wire logic wr_commit,
  output logic serial_out,
  output logic volt_start,
  output logic volt_use_aux,
  output logic volt_busy,
  output logic cur_start
);
  import bmr_pkg::*;

  logic [15:0] temperature_result;
  logic [15:0] voltage_result;
  logic [15:0] current_result;
  logic [15:0] current_offset_calibration;
  logic [15:0] rd_shreg;
  logic [15:0] wr_shreg;
  logic [SAMPLE_CNT_W-1:0] sample_cnt;
  bmr_cur_state_t cur_state;
  logic [15:0] sel_word;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [12:0] clamp_temp(input logic [12:0] raw);
    if ($signed(raw) > $signed(TEMP_MAX_CODE))
    begin
      return TEMP_MAX_CODE;
    end
    if ($signed(raw) < $signed(TEMP_MIN_CODE))
    begin
      return TEMP_MIN_CODE;
    end
    return raw;
  endfunction

  // Offset sum, saturated to the 10-bit signed range then sign extended
  function automatic logic [15:0] cur_word(input logic [9:0] raw, input logic [15:0] ofs);
    logic [16:0] sum;
    logic [9:0] val;
    sum = 17'({{7{raw[9]}}, raw}) + 17'({ofs[15], ofs});
    val = sum[9:0];
    if (!sum[16] && (sum[15:9] != 7'h00))
    begin
      val = CUR_POS_LIMIT;
    end
    if (sum[16] && (sum[15:9] != 7'h7F))
    begin
      val = CUR_NEG_LIMIT;
    end
    return {{6{val[9]}}, val};
  endfunction

  always_comb
  begin
    unique case (reg_sel)
      SEL_TEMPERATURE: sel_word = temperature_result;
      SEL_VOLTAGE: sel_word = voltage_result;
      SEL_CURRENT: sel_word = current_result;
      SEL_OFFSET: sel_word = current_offset_calibration;
    endcase
  end

  // ****************************************
  // Temperature result
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      temperature_result <= RESULT_RESET;
    end
    else if (temp_done)
    begin
      temperature_result <= {clamp_temp(temp_raw), {TEMP_FRAC_ZEROS{1'b0}}};
    end
  end

  // ****************************************
  // Voltage conversion on command
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      volt_start <= 1'b0;
      volt_busy <= 1'b0;
      volt_use_aux <= 1'b0;
      voltage_result <= RESULT_RESET;
    end
    else
    begin
      volt_start <= 1'b0;
      if (cmd_convert_v && !volt_busy)
      begin
        volt_start <= 1'b1;
        volt_busy <= 1'b1;
        volt_use_aux <= cfg_use_aux;
      end
      else if (volt_done && volt_busy)
      begin
        volt_busy <= 1'b0;
        voltage_result <= {VOLT_PAD, volt_code};
      end
    end
  end

  // ****************************************
  // Background current sampling
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cur_state <= BMR_CUR_IDLE;
      sample_cnt <= '0;
      cur_start <= 1'b0;
      current_result <= RESULT_RESET;
    end
    else
    begin
      cur_start <= 1'b0;
      if (!current_adc_enable)
      begin
        cur_state <= BMR_CUR_IDLE;
        sample_cnt <= '0;
      end
      else
      begin
        sample_cnt <= (sample_cnt == SAMPLE_CNT_W'(SAMPLE_PERIOD - 1)) ? '0 : sample_cnt + 1'b1;
        unique case (cur_state)
          BMR_CUR_IDLE:
          begin
            cur_state <= BMR_CUR_WAIT;
            sample_cnt <= '0;
          end
          BMR_CUR_WAIT:
          begin
            if (sample_cnt == SAMPLE_CNT_W'(SAMPLE_PERIOD - 1))
            begin
              cur_start <= 1'b1;
              cur_state <= BMR_CUR_CONV;
            end
          end
          BMR_CUR_CONV:
          begin
            if (cur_done)
            begin
              current_result <= cur_word(cur_raw, current_offset_calibration);
              cur_state <= BMR_CUR_WAIT;
            end
          end
          default:
          begin
            cur_state <= BMR_CUR_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Serial register access, LSB first
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rd_shreg <= RESULT_RESET;
      serial_out <= 1'b0;
    end
    else if (rd_load)
    begin
      rd_shreg <= {1'b0, sel_word[15:1]};
      serial_out <= sel_word[0];
    end
    else if (rd_shift)
    begin
      rd_shreg <= {1'b0, rd_shreg[15:1]};
      serial_out <= rd_shreg[0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wr_shreg <= RESULT_RESET;
      current_offset_calibration <= OFFSET_RESET;
    end
    else
    begin
      if (wr_shift)
      begin
        wr_shreg <= {wr_bit, wr_shreg[15:1]};
      end
      // Writes while sampling would corrupt results, so they are dropped
      if (wr_commit && reg_sel == SEL_OFFSET && !current_adc_enable)
      begin
        current_offset_calibration <= {{OFFSET_SIGN_BITS{wr_shreg[11]}}, wr_shreg[11:0]};
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [SAMPLE_CNT_W:0] gap_cnt;
  logic cur_seen;
  always_ff @(posedge sys_clk)
  begin
    if (srst || !current_adc_enable)
    begin
      gap_cnt <= '0;
      cur_seen <= 1'b0;
    end
    else if (cur_start)
    begin
      gap_cnt <= '0;
      cur_seen <= 1'b1;
    end
    else
    begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  temp_low_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    temperature_result[2:0] == 3'h0) else $error("temperature low bits not zero");
  temp_range_a: assert property (@(posedge sys_clk) disable iff (srst)
    temp_done |=> ($signed(temperature_result) <= $signed(16'h7D00))
      && ($signed(temperature_result) >= $signed(16'hC900))) else $error("temperature out of range");
  volt_cmd_only_a: assert property (@(posedge sys_clk) disable iff (srst)
    volt_start |-> $past(cmd_convert_v) && !$past(volt_busy)) else $error("voltage start without command");
  volt_store_a: assert property (@(posedge sys_clk) disable iff (srst)
    volt_busy && volt_done && !cmd_convert_v |=> voltage_result == {6'h00, $past(volt_code)})
    else $error("voltage result wrong");
  volt_input_a: assert property (@(posedge sys_clk) disable iff (srst)
    volt_start |-> volt_use_aux == $past(cfg_use_aux)) else $error("voltage input select wrong");
  cur_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
    !current_adc_enable |=> !cur_start) else $error("sample while disabled");
  cur_period_a: assert property (@(posedge sys_clk) disable iff (srst)
    cur_start |-> gap_cnt == (cur_seen ? (SAMPLE_CNT_W + 1)'(SAMPLE_PERIOD - 1)
      : (SAMPLE_CNT_W + 1)'(SAMPLE_PERIOD + 1)))
    else $error("sample period wrong");
  cur_sign_a: assert property (@(posedge sys_clk) disable iff (srst)
    current_result[15:10] == {6{current_result[9]}}) else $error("current sign copies wrong");
  cur_update_a: assert property (@(posedge sys_clk) disable iff (srst)
    cur_state == BMR_CUR_CONV && cur_done && current_adc_enable
      |=> current_result == cur_word($past(cur_raw), $past(current_offset_calibration)))
    else $error("current result not offset sum");
  cur_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    !(cur_state == BMR_CUR_CONV && cur_done) |=> $stable(current_result))
    else $error("current result changed mid sample");
  ofs_sign_a: assert property (@(posedge sys_clk) disable iff (srst)
    current_offset_calibration[15:12] == {4{current_offset_calibration[11]}})
    else $error("offset sign bits wrong");
  ser_lsb_a: assert property (@(posedge sys_clk) disable iff (srst)
    rd_load |=> serial_out == $past(sel_word[0])) else $error("serial not lsb first");
endmodule

// File: testbench/bmr_host.sv
module bmr_host (
  input wire logic sys_clk,
  input wire logic serial_out,
  output logic [1:0] reg_sel,
  output logic rd_load,
  output logic rd_shift,
  output logic wr_shift,
  output logic wr_bit,
  output logic wr_commit
);
  timeunit 1ns;
  timeprecision 1ps;
  import bmr_pkg::*;
  initial
  begin
    {reg_sel, rd_load, rd_shift, wr_shift, wr_bit, wr_commit} = 7'h00;
  end
  // ****************************************
  // Register read, bit 0 first
  // ****************************************
  task automatic read_reg(input logic [1:0] sel, output logic [15:0] d);
    @(negedge sys_clk);
    reg_sel = sel;
    rd_load = 1'b1;
    @(negedge sys_clk);
    rd_load = 1'b0;
    rd_shift = 1'b1;
    d[0] = serial_out;
    for (int i = 1; i < 16; i++)
    begin
      @(negedge sys_clk);
      d[i] = serial_out;
    end
    rd_shift = 1'b0;
  endtask
  // ****************************************
  // Offset write, caller keeps the converter off
  // ****************************************
  task automatic write_offset(input logic [15:0] d);
    @(negedge sys_clk);
    reg_sel = SEL_OFFSET;
    wr_shift = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      wr_bit = d[i];
      @(negedge sys_clk);
    end
    wr_shift = 1'b0;
    wr_commit = 1'b1;
    @(negedge sys_clk);
    wr_commit = 1'b0;
  endtask
endmodule

// File: testbench/tb_battery_measurement_readout.sv
module tb_battery_measurement_readout;
  timeunit 1ns;
  timeprecision 1ps;
  import bmr_pkg::*;
  localparam int P = 20;
  `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
  logic sys_clk, srst, current_adc_enable, cfg_use_aux, cmd_convert_v;
  logic temp_done, volt_done, cur_done, serial_out, volt_start, volt_use_aux;
  logic volt_busy, cur_start, rd_load, rd_shift, wr_shift, wr_bit, wr_commit;
  logic [12:0] temp_raw;
  logic [9:0] volt_code;
  logic [9:0] cur_raw;
  logic [1:0] reg_sel;
  logic [15:0] d;
  int mismatches, checks_done, cyc, n, t0;
  bmr_readout #(.SAMPLE_PERIOD(P)) dut (.sys_clk, .srst, .current_adc_enable,
    .cfg_use_aux, .cmd_convert_v, .temp_done, .temp_raw, .volt_done, .volt_code,
    .cur_done, .cur_raw, .reg_sel, .rd_load, .rd_shift, .wr_shift, .wr_bit,
    .wr_commit, .serial_out, .volt_start, .volt_use_aux, .volt_busy, .cur_start);
  bmr_host host (.sys_clk, .serial_out, .reg_sel, .rd_load, .rd_shift, .wr_shift,
    .wr_bit, .wr_commit);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_start();
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (cur_start !== 1'b1 && n < 3 * P);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    for (int s = 0; s < 4; s++)
    begin
      host.read_reg(2'(s), d);
      `CHK(d, RESULT_RESET)
    end
    `CHK({volt_busy, cur_start}, 2'b00)
    $display("reset test done");
  endtask
  task automatic test_temp();
    logic [12:0] tr[6];
    logic [15:0] te[6];
    tr = '{13'h0FA0, 13'h1920, 13'h0322, 13'h1CDE, 13'h0FA8, 13'h1900};
    te = '{16'h7D00, 16'hC900, 16'h1910, 16'hE6F0, 16'h7D00, 16'hC900};
    foreach (tr[i])
    begin
      @(negedge sys_clk);
      temp_done = 1'b1;
      temp_raw = tr[i];
      @(negedge sys_clk);
      temp_done = 1'b0;
      host.read_reg(SEL_TEMPERATURE, d);
      `CHK(d, te[i])
    end
    $display("temperature test done");
  endtask
  task automatic test_volt();
    logic [10:0] tv[2];
    logic [15:0] prev;
    tv = '{{1'b1, 10'h3E8}, {1'b0, 10'h1F4}};
    prev = 16'h0000;
    foreach (tv[i])
    begin
      @(negedge sys_clk);
      volt_done = 1'b1;
      volt_code = ~tv[i][9:0];
      @(negedge sys_clk);
      volt_done = 1'b0;
      `CHK(volt_start, 1'b0)
      host.read_reg(SEL_VOLTAGE, d);
      `CHK(d, prev)
      @(negedge sys_clk);
      cfg_use_aux = tv[i][10];
      cmd_convert_v = 1'b1;
      @(negedge sys_clk);
      cmd_convert_v = 1'b0;
      `CHK({volt_start, volt_busy, volt_use_aux}, {2'b11, tv[i][10]})
      @(negedge sys_clk);
      cmd_convert_v = 1'b1;
      `CHK(volt_start, 1'b0)
      @(negedge sys_clk);
      cmd_convert_v = 1'b0;
      volt_done = 1'b1;
      volt_code = tv[i][9:0];
      `CHK(volt_start, 1'b0)
      @(negedge sys_clk);
      volt_done = 1'b0;
      `CHK(volt_busy, 1'b0)
      prev = {6'h00, tv[i][9:0]};
      host.read_reg(SEL_VOLTAGE, d);
      `CHK(d, prev)
    end
    $display("voltage test done");
  endtask
  task automatic test_cur();
    host.write_offset(16'h0FFB);
    host.read_reg(SEL_OFFSET, d);
    `CHK(d, 16'hFFFB)
    @(negedge sys_clk);
    current_adc_enable = 1'b1;
    wait_start();
    `CHK(n, P + 1)
    t0 = cyc;
    cur_done = 1'b1;
    cur_raw = 10'h080;
    @(negedge sys_clk);
    cur_done = 1'b0;
    host.read_reg(SEL_CURRENT, d);
    `CHK(d, 16'h007B)
    wait_start();
    `CHK(cyc - t0, P)
    host.read_reg(SEL_CURRENT, d);
    `CHK(d, 16'h007B)
    cur_done = 1'b1;
    cur_raw = 10'h380;
    @(negedge sys_clk);
    cur_done = 1'b0;
    current_adc_enable = 1'b0;
    host.read_reg(SEL_CURRENT, d);
    `CHK(d, 16'hFF7B)
    wait_start();
    `CHK(cur_start, 1'b0)
    $display("current test done");
  endtask
  initial
  begin
    {sys_clk, srst, current_adc_enable, cfg_use_aux, cmd_convert_v} = 5'h08;
    {temp_done, volt_done, cur_done, temp_raw, volt_code, cur_raw} = 36'h0;
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    test_reset();
    test_temp();
    test_volt();
    test_cur();
    test_done();
  end
endmodule
